// ===== common/droop_pkg.sv
// Purpose: constants for the supply droop detector control block
// Assumes: 8-bit register port, one register plus flag/enable register
// Notes: offsets are word indices on the plain register port
package droop_pkg;
  localparam logic [1:0] CTRL_OFFSET = 2'h0;
  localparam logic [1:0] IRQ_OFFSET = 2'h1;
  localparam int TRIP_LSB = 0;
  localparam int TRIP_MSB = 3;
  localparam int ENABLE_BIT = 4;
  localparam int STABLE_BIT = 5;
  localparam int IRQ_FLAG_BIT = 0;
  localparam int IRQ_ENABLE_BIT = 1;
  localparam int GLOBAL_ENABLE_BIT = 2;
  localparam logic [3:0] TRIP_RESET = 4'h5;
  localparam logic [3:0] TRIP_EXTERNAL = 4'hf;
  localparam logic [3:0] TRIP_RESERVED = 4'h0;
  localparam logic ENABLE_RESET = 1'b0;
  // fewest powered cycles before the synchronised stable level can arm the flag
  localparam logic [3:0] SETTLE_MIN_CYCLES = 4'h3;
endpackage

// ===== sim/analog_partner.sv
// Purpose: comparator, divider and reference model beside the droop block
// Assumes: higher trip code means higher threshold
// Notes: output is junk until the reference settles
`timescale 1ns/100ps
module analog_partner (
  input wire logic clk_sys_in,
  input wire logic power_en_in,
  input wire logic [3:0] trip_in,
  input wire logic ext_sel_in,
  input wire logic [3:0] supply_level_in,
  input wire logic ext_low_in,
  output logic comparator_low_out,
  output logic reference_stable_out
);
  logic toggle_reg = 1'b0;
  initial reference_stable_out = 1'b0;
  always @(posedge clk_sys_in) toggle_reg <= ~toggle_reg;
  // settle time in ns, not cycles
  always begin
    wait (power_en_in);
    #150;
    reference_stable_out = power_en_in;
    wait (!power_en_in);
    reference_stable_out = 1'b0;
  end
  assign comparator_low_out = !reference_stable_out ? toggle_reg :
    ext_sel_in ? ext_low_in : (trip_in > supply_level_in);
endmodule

// ===== sim/testbench.sv
// Purpose: self-checking bench of the supply droop detector
// Assumes: register port reads answer one cycle after the strobe
// Notes: analog side comes from analog_partner
`timescale 1ns/100ps
module testbench;
  import droop_pkg::*;
  logic clk_sys_in = 1'b0, rst_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, sleep_in = 1'b0;
  logic [1:0] addr_in = 2'h0;
  logic [7:0] wdata_in = 8'h00, rdata_out, v;
  logic cmp_low, ref_ok, pwr, ext, vec, wake, ext_low = 1'b0;
  logic [3:0] trip, level = 4'hf;
  int n_fail = 0, n_checks = 0, cycles = 0;
  supply_droop_detector supply_droop_detector_inst (.clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .comparator_low_in(cmp_low),
    .reference_stable_in(ref_ok), .sleep_in(sleep_in), .detector_power_enable_out(pwr),
    .trip_select_out(trip), .use_external_trip_input_out(ext),
    .vector_request_out(vec), .wake_out(wake));
  analog_partner analog_partner_inst (.clk_sys_in(clk_sys_in), .power_en_in(pwr),
    .trip_in(trip), .ext_sel_in(ext), .supply_level_in(level), .ext_low_in(ext_low),
    .comparator_low_out(cmp_low), .reference_stable_out(ref_ok));
  always #2.5 clk_sys_in = ~clk_sys_in;
  // ----------------------------------------
  // bus and check helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    wr_in <= 1'b1; addr_in <= a; wdata_in <= d;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_sys_in);
    rd_in <= 1'b1; addr_in <= a;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1;
    check(what, rdata_out, exp);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(CTRL_OFFSET, 8'h05, "ctrl reset");
    rd(IRQ_OFFSET, 8'h00, "irq reset");
    check("power", {7'h0, pwr}, 8'h00);
    rd(2'h2, 8'h00, "unmapped");
  endtask
  task automatic t_codes();
    for (int c = 1; c < 16; c++) begin
      wr(CTRL_OFFSET, {4'he, 4'(c)});
      check("trip", {4'h0, trip}, 8'(c));
      check("ext", {7'h0, ext}, {7'h0, c == 15});
      rd(CTRL_OFFSET, {4'h0, 4'(c)}, "ctrl upper");
    end
  endtask
  task automatic t_enable();
    level <= 4'h8;
    wr(CTRL_OFFSET, 8'h14);
    check("power on", {7'h0, pwr}, 8'h01);
    rd(CTRL_OFFSET, 8'h14, "not stable");
    repeat (15) @(posedge clk_sys_in);
    rd(IRQ_OFFSET, 8'h00, "no flag early");
    repeat (30) @(posedge clk_sys_in);
    rd(CTRL_OFFSET, 8'h34, "stable");
    wr(IRQ_OFFSET, 8'h00);
    rd(IRQ_OFFSET, 8'h00, "no trip");
    wr(CTRL_OFFSET, 8'h1a);
    repeat (8) @(posedge clk_sys_in);
    rd(IRQ_OFFSET, 8'h01, "tripped");
  endtask
  task automatic t_irq();
    level <= 4'hf;
    repeat (8) @(posedge clk_sys_in);
    wr(IRQ_OFFSET, 8'h02);
    rd(IRQ_OFFSET, 8'h02, "cleared");
    sleep_in <= 1'b1;
    level <= 4'h0;
    repeat (8) @(posedge clk_sys_in);
    #1;
    check("wake", {6'h0, wake, vec}, 8'h02);
    wr(IRQ_OFFSET, 8'h07);
    check("vector", {7'h0, vec}, 8'h01);
    wr(CTRL_OFFSET, 8'h0a);
    rd(CTRL_OFFSET, 8'h0a, "power off");
    wr(CTRL_OFFSET, 8'h13);
    rst_n_in <= 1'b0;
    #1;
    check("mid reset", {3'h0, pwr, trip}, 8'h05);
  endtask
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      finish_test();
    end
  end
  initial begin
    repeat (5) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_codes();
    t_enable();
    t_irq();
    finish_test();
  end
endmodule

// ===== src/supply_droop_detector.sv
// Purpose: control, flag and wake logic of a supply droop detector
// Assumes: analog comparator and reference outside; asynchronous outputs
// Notes: flag and enables sit in a second register of their own
`timescale 1ns/100ps

module supply_droop_detector
  import droop_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic comparator_low_in,
  input wire logic reference_stable_in,
  input wire logic sleep_in,
  output logic detector_power_enable_out,
  output logic [3:0] trip_select_out,
  output logic use_external_trip_input_out,
  output logic vector_request_out,
  output logic wake_out
);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [3:0] trip_select_reg;
  logic detector_power_enable_reg;
  logic low_voltage_irq_flag_reg;
  logic low_voltage_irq_enable_reg;
  logic global_irq_enable_reg;
  logic [2:0] cmp_sync_reg;
  logic [2:0] stb_sync_reg;
  logic cmp_low;
  logic ref_stable;
  logic stable_flag;
  logic set_flag;
  logic clr_flag;
  logic wr_ctrl;
  logic wr_irq;
  logic [3:0] powered_cycles_reg;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // true when the port index selects the given register
  function automatic logic index_hit(input logic [1:0] index, input logic [1:0] target);
    return index == target;
  endfunction

  // a synchronised level moves only once stages two and three agree
  function automatic logic settled_level(input logic [2:0] stages, input logic held);
    logic result;
    result = held;
    if (stages[1] == stages[2]) begin
      result = stages[2];
    end
    return result;
  endfunction

  // read image of the control register; upper two bits are unimplemented
  function automatic logic [7:0] ctrl_image(input logic stable, input logic enable,
                                            input logic [3:0] trip);
    return {2'h0, stable, enable, trip};
  endfunction

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  // the logic packs every field into one byte with a four bit trip code
  if (TRIP_MSB - TRIP_LSB != 3) begin : g_trip_width_bad
    $error("trip select field must be four bits wide");
  end
  if (ENABLE_BIT > 7 || STABLE_BIT > 7 || GLOBAL_ENABLE_BIT > 7) begin : g_bit_pos_bad
    $error("field positions must fit one byte");
  end

  assign wr_ctrl = wr_in && index_hit(addr_in, CTRL_OFFSET);
  assign wr_irq = wr_in && index_hit(addr_in, IRQ_OFFSET);

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  // three stages; a change counts once stages two and three agree
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cmp_sync_reg <= 3'h0;
      stb_sync_reg <= 3'h0;
    end else begin
      cmp_sync_reg <= {cmp_sync_reg[1:0], comparator_low_in};
      // a stale stable level must not survive a power cycle
      if (detector_power_enable_reg) begin
        stb_sync_reg <= {stb_sync_reg[1:0], reference_stable_in};
      end else begin
        stb_sync_reg <= 3'h0;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cmp_low <= 1'b0;
      ref_stable <= 1'b0;
    end else begin
      cmp_low <= settled_level(cmp_sync_reg, cmp_low);
      if (!detector_power_enable_reg) begin
        ref_stable <= 1'b0;
      end else begin
        ref_stable <= settled_level(stb_sync_reg, ref_stable);
      end
    end
  end

  // stable only counts while powered; the analog signal ends it, no timer
  assign stable_flag = detector_power_enable_reg && ref_stable;

  // cycles since power-up, saturating; only the checks read it
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      powered_cycles_reg <= 4'h0;
    end else if (!detector_power_enable_reg) begin
      powered_cycles_reg <= 4'h0;
    end else if (powered_cycles_reg != 4'hf) begin
      powered_cycles_reg <= powered_cycles_reg + 4'h1;
    end
  end

  // ------------------------------------------------------------
  // control register and interrupt enable bits
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      trip_select_reg <= TRIP_RESET;
      detector_power_enable_reg <= ENABLE_RESET;
    end else if (wr_ctrl) begin
      trip_select_reg <= wdata_in[TRIP_MSB:TRIP_LSB];
      detector_power_enable_reg <= wdata_in[ENABLE_BIT];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      low_voltage_irq_enable_reg <= 1'b0;
      global_irq_enable_reg <= 1'b0;
    end else if (wr_irq) begin
      low_voltage_irq_enable_reg <= wdata_in[IRQ_ENABLE_BIT];
      global_irq_enable_reg <= wdata_in[GLOBAL_ENABLE_BIT];
    end
  end

  // ------------------------------------------------------------
  // flag
  // ------------------------------------------------------------
  // comparator keeps running in sleep, so no sleep term here
  assign set_flag = stable_flag && cmp_low;
  assign clr_flag = wr_irq && !wdata_in[IRQ_FLAG_BIT];

  // set wins over a simultaneous software clear
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      low_voltage_irq_flag_reg <= 1'b0;
    end else if (set_flag) begin
      low_voltage_irq_flag_reg <= 1'b1;
    end else if (clr_flag) begin
      low_voltage_irq_flag_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      case (addr_in)
        CTRL_OFFSET: rdata_out <= ctrl_image(stable_flag, detector_power_enable_reg,
                                             trip_select_reg);
        IRQ_OFFSET: rdata_out <= {5'h00, global_irq_enable_reg,
                                  low_voltage_irq_enable_reg, low_voltage_irq_flag_reg};
        default: rdata_out <= 8'h00;
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign detector_power_enable_out = detector_power_enable_reg;
  assign trip_select_out = trip_select_reg;
  assign use_external_trip_input_out = (trip_select_reg == TRIP_EXTERNAL);
  // wake needs only the local enable; vectoring also needs the global one
  assign wake_out = sleep_in && low_voltage_irq_flag_reg
                    && low_voltage_irq_enable_reg;
  assign vector_request_out = low_voltage_irq_flag_reg && low_voltage_irq_enable_reg
                              && global_irq_enable_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence trip_seen;
    stable_flag && cmp_low;
  endsequence

  sequence ctrl_read_req;
    rd_in && addr_in == CTRL_OFFSET;
  endsequence

  sequence flag_clear_req;
    wr_irq && !wdata_in[IRQ_FLAG_BIT];
  endsequence

  sequence power_rise;
    $rose(detector_power_enable_reg);
  endsequence

  AST_FLAG_SETS: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    trip_seen |=> low_voltage_irq_flag_reg)
    else $error("flag not set after trip");
  AST_NO_FLAG_UNSTABLE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (!low_voltage_irq_flag_reg && !stable_flag) |=> !low_voltage_irq_flag_reg)
    else $error("flag set before reference stable");
  AST_EXT_SELECT: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    use_external_trip_input_out == (trip_select_out == 4'hf))
    else $error("external input select wrong");
  AST_CTRL_WRITE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    wr_ctrl |=> detector_power_enable_out == $past(wdata_in[ENABLE_BIT]))
    else $error("enable bit not written");
  AST_TRIP_WRITE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    wr_ctrl |=> trip_select_out == $past(wdata_in[3:0]))
    else $error("trip select not written");
  AST_UPPER_ZERO: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    rd_in && addr_in == CTRL_OFFSET |=> rdata_out[7:6] == 2'h0)
    else $error("upper control bits not zero");
  AST_STABLE_READ: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    rd_in && addr_in == CTRL_OFFSET && !detector_power_enable_reg |=> !rdata_out[5])
    else $error("stable reads one while off");
  AST_VECTOR: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    vector_request_out |-> global_irq_enable_reg && low_voltage_irq_enable_reg)
    else $error("vector without enables");
  AST_SYNC_DELAY: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(cmp_low) |-> $past(cmp_sync_reg[2]) && $past(cmp_sync_reg[1]))
    else $error("comparator used unsynchronised");
  AST_WAKE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (sleep_in && low_voltage_irq_enable_reg) and trip_seen
      |=> wake_out || !sleep_in || !low_voltage_irq_enable_reg)
    else $error("no wake on trip in sleep");

  // ------------------------------------------------------------
  // checks: flag and arming
  // ------------------------------------------------------------
  AST_SET_WINS: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    flag_clear_req and trip_seen |=> low_voltage_irq_flag_reg)
    else $error("software clear beat a trip");
  AST_FLAG_CLEARS: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    flag_clear_req ##0 !set_flag |=> !low_voltage_irq_flag_reg)
    else $error("flag not cleared by software");
  AST_FLAG_HOLDS: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    low_voltage_irq_flag_reg && !wr_irq |=> low_voltage_irq_flag_reg)
    else $error("flag dropped without a clear");
  AST_NO_SOFT_SET: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !low_voltage_irq_flag_reg && !set_flag |=> !low_voltage_irq_flag_reg)
    else $error("flag set without a trip");
  AST_SLEEP_KEEPS: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    sleep_in ##0 trip_seen |=> low_voltage_irq_flag_reg)
    else $error("trip in sleep did not set the flag");
  AST_POWER_UP_QUIET: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    power_rise |-> !stable_flag [*3])
    else $error("stable reported right after power-up");
  AST_NO_EARLY_SET: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    set_flag |-> powered_cycles_reg >= SETTLE_MIN_CYCLES)
    else $error("flag armed before the reference could settle");
  AST_STABLE_NEEDS_REF: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    stable_flag |-> ref_stable)
    else $error("stable shown without the analog stable level");
  AST_STABLE_OFF: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !detector_power_enable_reg |-> !stable_flag)
    else $error("stable shown while powered down");
  AST_STABLE_SYNC: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(ref_stable) |-> $past(stb_sync_reg[2]) && $past(stb_sync_reg[1]))
    else $error("reference stable used unsynchronised");

  // ------------------------------------------------------------
  // checks: register port and outputs
  // ------------------------------------------------------------
  AST_CTRL_READ: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    ctrl_read_req |=> rdata_out == ctrl_image($past(stable_flag),
      $past(detector_power_enable_reg), $past(trip_select_reg)))
    else $error("control read image wrong");
  AST_UNMAPPED_READ: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    rd_in && addr_in > IRQ_OFFSET |=> rdata_out == 8'h00)
    else $error("unmapped index read not zero");
  AST_READ_IDLE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !rd_in |=> rdata_out == 8'h00)
    else $error("read data outside its cycle");
  AST_IRQ_WRITE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    wr_irq |=> low_voltage_irq_enable_reg == $past(wdata_in[IRQ_ENABLE_BIT])
      && global_irq_enable_reg == $past(wdata_in[GLOBAL_ENABLE_BIT]))
    else $error("interrupt enables not written");
  AST_POWER_HOLDS: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !wr_ctrl |=> $stable(detector_power_enable_out))
    else $error("power enable moved without a write");
  AST_TRIP_HOLDS: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !wr_ctrl |=> $stable(trip_select_out))
    else $error("trip select moved without a write");
  AST_VECTOR_RAISED: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    low_voltage_irq_flag_reg && low_voltage_irq_enable_reg && global_irq_enable_reg
      |-> vector_request_out)
    else $error("vector not requested");
  AST_VECTOR_GLOBAL: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !global_irq_enable_reg |-> !vector_request_out)
    else $error("vector without global enable");
  AST_WAKE_ONLY_ASLEEP: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    wake_out |-> sleep_in && low_voltage_irq_flag_reg)
    else $error("wake outside sleep or without flag");
  AST_EXT_ONLY_CODE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    trip_select_out != TRIP_EXTERNAL |-> !use_external_trip_input_out)
    else $error("external input chosen by an internal code");
  AST_RESERVED_INTERNAL: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    trip_select_out == TRIP_RESERVED |-> !use_external_trip_input_out)
    else $error("reserved code routed to the external input");

endmodule
